// [src/igd_dio.sv]
/*
 * Inverting general I/O block: 48 open-drain lines in six byte ports, edge
 * detection with pending flags on the lowest 24 lines, one level interrupt.
 * Assumes an APB master on MCLK and external pull-ups on every pin.
 */
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module igd_dio (
    input wire logic MCLK, // 100 MHz block clock
    input wire logic RST, // synchronous reset, active high
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB direction, 1 = write
    input wire logic [igd_pkg::ADDR_W-1:0] PADDR, // APB byte address
    input wire logic [igd_pkg::DATA_W-1:0] PWDATA, // APB write data
    output logic [igd_pkg::DATA_W-1:0] PRDATA, // APB read data
    output logic PREADY, // APB ready, one cycle
    output logic PSLVERR, // APB error for unmapped address
    input wire logic [igd_pkg::NUM_LINES-1:0] PIN_IN, // pin levels
    output logic [igd_pkg::NUM_LINES-1:0] PIN_OUT, // pin drive level, always low
    output logic [igd_pkg::NUM_LINES-1:0] PIN_OE, // pin driven low when high
    output logic IRQ // level interrupt
);
    localparam int NL = igd_pkg::NUM_LINES;
    localparam int NE = igd_pkg::EDGE_LINES;

    igd_pkg::igd_apb_req_s req;
    logic [NL-1:0] pin_sync;
    logic [NL-1:0] port_data;
    logic [NL-1:0] next_port_data;
    logic [NE-1:0] edge_en;
    logic [NE-1:0] next_edge_en;
    logic [NE-1:0] edge_pol;
    logic [NE-1:0] next_edge_pol;
    logic [NE-1:0] irq_stat;
    logic [NE-1:0] next_irq_stat;
    logic [NE-1:0] irq_mask;
    logic [NE-1:0] next_irq_mask;
    logic [NE-1:0] pin_prev;
    logic [NE-1:0] edge_hit;
    logic [igd_pkg::DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    logic setup_acc;
    logic commit;

    assign req = '{sel: PSEL, en: PENABLE, wr: PWRITE, addr: PADDR, wdata: PWDATA};
    // first access cycle answers, the edge that sees PREADY commits the write
    assign setup_acc = req.sel && req.en && !PREADY;
    assign commit = req.sel && req.en && PREADY;

    ////////////////////////////////////////////////////////////////////////////
    // pin input synchronisation

    igd_sync #(
        .WIDTH(NL)
    ) u_sync (
        .clk(MCLK),
        .rst(RST),
        .d(PIN_IN),
        .q(pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // edge detection, one slice per edge-capable line

    genvar gi;
    generate
        for (gi = 0; gi < NE; gi++)
        begin : g_edge
            // polarity 1 = rising pin level, 0 = falling
            assign edge_hit[gi] = edge_en[gi] && (edge_pol[gi] ?
                (pin_sync[gi] && !pin_prev[gi]) :
                (!pin_sync[gi] && pin_prev[gi]));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // register file and bus answer

    always_comb
    begin
        next_port_data = port_data;
        next_edge_en = edge_en;
        next_edge_pol = edge_pol;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_prdata = PRDATA;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (setup_acc)
        begin
            next_pready = 1'b1;
            next_prdata = '0;
            if (req.addr < igd_pkg::OFF_EDGE_EN && req.addr[1:0] == 2'h0)
            begin
                for (int p = 0; p < igd_pkg::NUM_PORTS; p++)
                begin
                    if (req.addr[4:2] == 3'(p))
                    begin
                        // inverted pin level, driven lines read as written
                        next_prdata[7:0] = ~pin_sync[p*8 +: 8];
                    end
                end
            end
            else if (req.addr == igd_pkg::OFF_EDGE_EN)
            begin
                next_prdata[NE-1:0] = edge_en;
            end
            else if (req.addr == igd_pkg::OFF_EDGE_POL)
            begin
                next_prdata[NE-1:0] = edge_pol;
            end
            else if (req.addr == igd_pkg::OFF_IRQ_STAT)
            begin
                next_prdata[NE-1:0] = irq_stat;
            end
            else if (req.addr == igd_pkg::OFF_IRQ_MASK)
            begin
                next_prdata[NE-1:0] = irq_mask;
            end
            else
            begin
                next_pslverr = 1'b1;
            end
        end
        if (commit && req.wr && !PSLVERR)
        begin
            if (req.addr < igd_pkg::OFF_EDGE_EN)
            begin
                for (int p = 0; p < igd_pkg::NUM_PORTS; p++)
                begin
                    if (req.addr[4:2] == 3'(p))
                    begin
                        // each bit is its own direction: 1 pulls low, 0 releases
                        next_port_data[p*8 +: 8] = req.wdata[7:0];
                    end
                end
            end
            else if (req.addr == igd_pkg::OFF_EDGE_EN)
            begin
                next_edge_en = req.wdata[NE-1:0];
            end
            else if (req.addr == igd_pkg::OFF_EDGE_POL)
            begin
                next_edge_pol = req.wdata[NE-1:0];
            end
            else if (req.addr == igd_pkg::OFF_IRQ_STAT)
            begin
                next_irq_stat = irq_stat & ~req.wdata[NE-1:0];
            end
            else if (req.addr == igd_pkg::OFF_IRQ_MASK)
            begin
                next_irq_mask = req.wdata[NE-1:0];
            end
        end
        // a new edge outranks a clear in the same cycle
        next_irq_stat = next_irq_stat | edge_hit;
        next_irq = |(irq_stat & irq_mask);
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            port_data <= igd_pkg::RST_PORTS;
            edge_en <= igd_pkg::RST_EDGE_EN;
            edge_pol <= igd_pkg::RST_EDGE_POL;
            irq_stat <= igd_pkg::RST_IRQ_STAT;
            irq_mask <= igd_pkg::RST_IRQ_MASK;
            pin_prev <= igd_pkg::RST_PIN_PREV;
            PRDATA <= '0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            IRQ <= 1'b0;
            PIN_OE <= '0;
            PIN_OUT <= '0;
        end
        else
        begin
            port_data <= next_port_data;
            edge_en <= next_edge_en;
            edge_pol <= next_edge_pol;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            pin_prev <= pin_sync[NE-1:0];
            PRDATA <= next_prdata;
            PREADY <= next_pready;
            PSLVERR <= next_pslverr;
            IRQ <= next_irq;
            // open drain: data 1 enables the low driver, data 0 floats high
            PIN_OE <= next_port_data;
            PIN_OUT <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    ready_wait_a: assert property (@(posedge MCLK) disable iff (RST)
        PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("access phase not answered in one cycle");

    ready_pulse_a: assert property (@(posedge MCLK) disable iff (RST)
        PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");

    drive_low_a: assert property (@(posedge MCLK) disable iff (RST)
        PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PADDR == igd_pkg::OFF_PORT0
        |=> PIN_OE[7:0] == $past(PWDATA[7:0]) && PIN_OUT[7:0] == 8'h00)
        else $error("port 0 write not reflected on drivers");

    readback_inv_a: assert property (@(posedge MCLK) disable iff (RST)
        PSEL && PENABLE && !PREADY && PADDR == igd_pkg::OFF_PORT0
        |=> PRDATA[7:0] == ~$past(pin_sync[7:0]) && PRDATA[31:8] == 24'h000000)
        else $error("port 0 read is not inverted pin level");

    edge_set_a: assert property (@(posedge MCLK) disable iff (RST)
        |edge_hit |=> (irq_stat & $past(edge_hit)) == $past(edge_hit))
        else $error("detected edge not held pending");

    edge_off_a: assert property (@(posedge MCLK) disable iff (RST)
        edge_en == 24'h000000 && irq_stat == 24'h000000 |=> irq_stat == 24'h000000)
        else $error("pending flag set with detection off");

    irq_level_a: assert property (@(posedge MCLK) disable iff (RST)
        |(irq_stat & irq_mask) |=> IRQ)
        else $error("interrupt not raised for pending edge");

    irq_clear_a: assert property (@(posedge MCLK) disable iff (RST)
        !(|(irq_stat & irq_mask)) |=> !IRQ)
        else $error("interrupt high with nothing pending");

    unmapped_err_a: assert property (@(posedge MCLK) disable iff (RST)
        PSEL && PENABLE && !PREADY && PADDR > igd_pkg::OFF_IRQ_MASK |=> PSLVERR && PREADY)
        else $error("unmapped access not flagged");

    err_ready_a: assert property (@(posedge MCLK) disable iff (RST)
        PSLVERR |-> PREADY)
        else $error("error flag without ready");

    read_upper_a: assert property (@(posedge MCLK) disable iff (RST)
        PREADY |-> PRDATA[31:24] == 8'h00)
        else $error("read data above the register width");

    idle_ready_a: assert property (@(posedge MCLK) disable iff (RST)
        !(PSEL && PENABLE) |=> !PREADY)
        else $error("ready without an access phase");

    read_hold_a: assert property (@(posedge MCLK) disable iff (RST)
        !(PSEL && PENABLE && !PREADY) |=> $stable(PRDATA))
        else $error("read data moved between answers");

    oe_steady_a: assert property (@(posedge MCLK) disable iff (RST)
        !(PSEL && PENABLE && PREADY && PWRITE) |=> $stable(PIN_OE))
        else $error("drivers changed without a write");

    // both flops must have left reset before the pipe holds real pin history
    sync_depth_a: assert property (@(posedge MCLK) disable iff (RST)
        !$past(RST) && !$past(RST, 2) |-> pin_sync == $past(PIN_IN, 2))
        else $error("pin synchroniser depth is not two");

    rise_detect_a: assert property (@(posedge MCLK) disable iff (RST)
        |(edge_en & edge_pol & pin_sync[NE-1:0] & ~pin_prev)
        |=> (irq_stat & $past(edge_en & edge_pol & pin_sync[NE-1:0] & ~pin_prev))
        == $past(edge_en & edge_pol & pin_sync[NE-1:0] & ~pin_prev))
        else $error("enabled rising edge not held pending");

    fall_detect_a: assert property (@(posedge MCLK) disable iff (RST)
        |(edge_en & ~edge_pol & ~pin_sync[NE-1:0] & pin_prev)
        |=> (irq_stat & $past(edge_en & ~edge_pol & ~pin_sync[NE-1:0] & pin_prev))
        == $past(edge_en & ~edge_pol & ~pin_sync[NE-1:0] & pin_prev))
        else $error("enabled falling edge not held pending");

    stat_hold_a: assert property (@(posedge MCLK) disable iff (RST)
        !(PSEL && PENABLE && PREADY && PWRITE && PADDR == igd_pkg::OFF_IRQ_STAT)
        |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
        else $error("pending flag lost without a clear");

    // flags move only on a write or on an enabled edge of the chosen sense
    stat_only_a: assert property (@(posedge MCLK) disable iff (RST)
        !(PSEL && PENABLE && PREADY && PWRITE) && !(|(edge_en
        & (edge_pol ^ ~pin_sync[NE-1:0]) & (pin_sync[NE-1:0] ^ pin_prev)))
        |=> irq_stat == $past(irq_stat))
        else $error("pending flag set without a qualifying edge");

    w1c_clear_a: assert property (@(posedge MCLK) disable iff (RST)
        PSEL && PENABLE && PREADY && PWRITE && PADDR == igd_pkg::OFF_IRQ_STAT && !(|edge_hit)
        |=> (irq_stat & $past(PWDATA[NE-1:0])) == 24'h000000)
        else $error("written one did not clear its flag");

    mask_write_a: assert property (@(posedge MCLK) disable iff (RST)
        PSEL && PENABLE && PREADY && PWRITE && PADDR == igd_pkg::OFF_IRQ_MASK
        |=> irq_mask == $past(PWDATA[NE-1:0]))
        else $error("mask write not taken");

    en_write_a: assert property (@(posedge MCLK) disable iff (RST)
        PSEL && PENABLE && PREADY && PWRITE && PADDR == igd_pkg::OFF_EDGE_EN
        |=> edge_en == $past(PWDATA[NE-1:0]))
        else $error("edge enable write not taken");

    edge_seen_c: cover property (@(posedge MCLK) disable iff (RST) |edge_hit ##1 IRQ);
    port_write_c: cover property (@(posedge MCLK) disable iff (RST)
        PSEL && PENABLE && PREADY && PWRITE && PADDR < igd_pkg::OFF_EDGE_EN);
    stat_clear_c: cover property (@(posedge MCLK) disable iff (RST)
        IRQ ##1 PSEL && PENABLE && PREADY && PWRITE && PADDR == igd_pkg::OFF_IRQ_STAT
        ##2 !IRQ);
    irq_masked_c: cover property (@(posedge MCLK) disable iff (RST) irq_stat != 24'h000000 && !IRQ);
    edge_rise_c: cover property (@(posedge MCLK) disable iff (RST) |(edge_hit & edge_pol));
endmodule // igd_dio
`default_nettype wire

// [src/igd_pkg.sv]
/*
 * Shared constants and types of the inverting general I/O block: line counts,
 * register offsets, reset values and the APB request carrier.
 * Assumes a 32-bit APB master on the same clock as the block.
 */
// Operation
// - Forty-eight general I/O lines, organised as six ports of eight bits.
// - Every line has its own direction; no group shares a setting.
// - Values are inverted between internal data and pin levels, both directions.
// - A written 0 releases the pin; pull-up holds it high, usable as input.
// - A written 1 drives the pin low.
// - Reads return inverted pin levels, so driven lines read back as written.
// - Only the lowest 24 lines carry edge detection.
// - Each edge-capable line has its own detection enable.
// - Each edge-capable line selects rising or falling transition.
// - Any selected, enabled transition raises the interrupt request; the code raises it only where the line's irq_mask bit is set.
package igd_pkg;
    localparam int NUM_PORTS = 6;
    localparam int PORT_W = 8;
    localparam int NUM_LINES = 48;
    localparam int EDGE_LINES = 24;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_PORT0 = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_EDGE_EN = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_EDGE_POL = 12'h01C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h024;
    localparam logic [NUM_LINES-1:0] RST_PORTS = 48'h000000000000;
    localparam logic [EDGE_LINES-1:0] RST_EDGE_EN = 24'h000000;
    localparam logic [EDGE_LINES-1:0] RST_EDGE_POL = 24'h000000;
    localparam logic [EDGE_LINES-1:0] RST_IRQ_STAT = 24'h000000;
    localparam logic [EDGE_LINES-1:0] RST_IRQ_MASK = 24'hFFFFFF;
    // pins idle high through their pull-ups
    localparam logic [EDGE_LINES-1:0] RST_PIN_PREV = 24'hFFFFFF;

    typedef struct packed {
        logic sel;
        logic en;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } igd_apb_req_s;
endpackage

// [src/igd_sync.sv]
/*
 * Two-flop synchroniser for a bus of independent level inputs.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/1ps
`default_nettype none
module igd_sync #(
    parameter int WIDTH = 48
) (
    input wire logic clk, // block clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [WIDTH-1:0] d, // asynchronous levels
    output logic [WIDTH-1:0] q // synchronised levels
);
    logic [WIDTH-1:0] meta;

    // reset to all ones: released pins sit high
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= '1;
            q <= '1;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // igd_sync
`default_nettype wire

// [tb/igd_pins.sv]
/*
 * Outside world of the I/O header: a pull-up on every line plus an outside
 * driver that can pull any line low.
 * Assumes the block only ever sinks current (open drain).
 */
`timescale 1ns/1ps
`default_nettype none
module igd_pins (
    input wire logic [igd_pkg::NUM_LINES-1:0] pin_out, // block drive level
    input wire logic [igd_pkg::NUM_LINES-1:0] pin_oe, // block drives when high
    input wire logic [igd_pkg::NUM_LINES-1:0] ext_low, // outside pulls low when high
    output logic [igd_pkg::NUM_LINES-1:0] pin_lvl // resolved wire level
);
    // a released line never keeps its old level: the pull-up wins
    always_comb
    begin
        for (int i = 0; i < igd_pkg::NUM_LINES; i++)
        begin
            pin_lvl[i] = 1'b1;
            if (pin_oe[i])
                pin_lvl[i] = pin_out[i];
            if (ext_low[i])
                pin_lvl[i] = 1'b0;
        end
    end
endmodule // igd_pins
`default_nettype wire

// [tb/test_inverting_dio_with_edge_irq.sv]
/*
 * Self-checking bench of the inverting I/O block: APB tasks, port and edge tests.
 * Assumes igd_pkg, igd_dio and the pin model igd_pins are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module test_inverting_dio_with_edge_irq;
logic mclk = 1'b0;
logic rst = 1'b1;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h00000000;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic irq;
logic [47:0] pin_out;
logic [47:0] pin_oe;
logic [47:0] pin_lvl;
logic [47:0] ext_low = 48'h000000000000;
logic [47:0] exp_oe;
logic [31:0] rd;
logic er;
int n_mismatch = 0;
int num_checks = 0;

always #5 mclk = ~mclk;

igd_dio dut_u (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PIN_IN(pin_lvl), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .IRQ(irq));
igd_pins pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_low(ext_low), .pin_lvl(pin_lvl));

////////////////////////////////////////////////////////////////////////////////
task chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
        n_mismatch++;
        $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
endtask

// one edge passes before setup, so back-to-back calls never drive psel twice at once
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no cycle limit here: a slave that never answers is caught by the watchdog
    do
    begin
        @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask

task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask

////////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    exp_oe = 48'h000000000000;
    for (int i = 0; i < 6; i++)
    begin
        apb(1'b1, igd_pkg::OFF_PORT0 + 12'(4 * i), 32'(8'hA5 ^ 8'(19 * i)));
        exp_oe[8*i +: 8] = 8'hA5 ^ 8'(19 * i);
    end
    @(posedge mclk);
    chk("pin_oe", pin_oe, exp_oe);
    chk("pin_out", pin_out, 48'h000000000000);
    for (int i = 0; i < 6; i++)
    begin
        apb(1'b0, igd_pkg::OFF_PORT0 + 12'(4 * i), 32'h00000000);
        chk("port readback", 48'(rd), 48'(exp_oe[8*i +: 8]));
        apb(1'b1, igd_pkg::OFF_PORT0 + 12'(4 * i), 32'h00000000);
    end
    @(posedge mclk);
    chk("pin_oe released", pin_oe, 48'h000000000000);
    // port traffic toggled lines 0..23 while detection was still off
    for (int i = 0; i < 3; i++)
    begin
        apb(1'b0, igd_pkg::OFF_EDGE_EN + 12'(4 * i), 32'h00000000);
        chk("edge reg reset", 48'(rd), 48'h000000000000);
    end
    apb(1'b0, igd_pkg::OFF_IRQ_MASK, 32'h00000000);
    chk("mask reset", 48'(rd), 48'h000000FFFFFF);
    chk("mapped no error", 48'(er), 48'h000000000000);
    ext_low <= 48'h000000000800;
    repeat (4) @(posedge mclk);
    apb(1'b0, igd_pkg::OFF_PORT0 + 12'h004, 32'h00000000);
    chk("port1 input", 48'(rd), 48'h000000000008);
    apb(1'b1, 12'h028, 32'h000000FF);
    chk("unmapped error", 48'(er), 48'h000000000001);
    apb(1'b0, 12'h002, 32'h00000000);
    chk("unaligned error", 48'(er), 48'h000000000001);
    chk("error read data", 48'(rd), 48'h000000000000);
    // line 0 falling enabled, line 5 rising enabled, line 1 off, line 30 has no detector
    apb(1'b1, igd_pkg::OFF_EDGE_EN, 32'h00000021);
    apb(1'b1, igd_pkg::OFF_EDGE_POL, 32'h00000020);
    ext_low <= 48'h000040000823;
    repeat (6) @(posedge mclk);
    apb(1'b0, igd_pkg::OFF_IRQ_STAT, 32'h00000000);
    chk("stat falling", 48'(rd), 48'h000000000001);
    chk("irq raised", 48'(irq), 48'h000000000001);
    ext_low <= 48'h000000000803;
    repeat (6) @(posedge mclk);
    apb(1'b0, igd_pkg::OFF_IRQ_STAT, 32'h00000000);
    chk("stat rising", 48'(rd), 48'h000000000021);
    apb(1'b1, igd_pkg::OFF_IRQ_STAT, 32'h00000001);
    apb(1'b0, igd_pkg::OFF_IRQ_STAT, 32'h00000000);
    chk("stat w1c", 48'(rd), 48'h000000000020);
    apb(1'b1, igd_pkg::OFF_IRQ_MASK, 32'h00000000);
    repeat (2) @(posedge mclk);
    chk("irq masked", 48'(irq), 48'h000000000000);
    apb(1'b1, igd_pkg::OFF_IRQ_MASK, 32'h00FFFFFF);
    apb(1'b1, igd_pkg::OFF_IRQ_STAT, 32'h00000020);
    repeat (2) @(posedge mclk);
    chk("irq cleared", 48'(irq), 48'h000000000000);
    // reset in mid-run: drivers must let go and settings return to their reset values
    apb(1'b1, igd_pkg::OFF_PORT0, 32'h000000FF);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("oe after reset", pin_oe, 48'h000000000000);
    apb(1'b0, igd_pkg::OFF_EDGE_EN, 32'h00000000);
    chk("enable after reset", 48'(rd), 48'h000000000000);
    apb(1'b0, igd_pkg::OFF_PORT0, 32'h00000000);
    chk("port0 after reset", 48'(rd), 48'h000000000003);
    give_verdict;
end

initial
begin
    #100000;
    n_mismatch++;
    give_verdict;
end
endmodule // test_inverting_dio_with_edge_irq
`default_nettype wire
